//--- dv/cfg_far_end_model.sv
// Far-end model: stalling reply sink and a small register bank
`timescale 1ns/1ps
`default_nettype none
module cfg_far_end_model
    import cfg_msg_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Reply tokens from the responder
    input wire logic tx_valid_i,
    input wire token_t tx_token_i,
    output logic tx_ready_o,
    // Bank access
    input wire logic reg_req_i,
    input wire logic reg_we_i,
    input wire reg_req_t reg_i,
    output logic reg_ack_o,
    output logic reg_err_o,
    output logic [31:0] reg_rdata_o
);
    logic [31:0] mem_reg [0:31] = '{default: 32'h0};
    logic [1:0] wait_reg = 2'h0;
    logic busy_reg = 1'b0;
    logic we_reg = 1'b0;
    logic done_now;
    reg_req_t req_reg;
    token_t got[$];
    initial tx_ready_o = 1'b0;
    initial reg_ack_o = 1'b0;
    initial reg_err_o = 1'b0;
    initial reg_rdata_o = 32'h0;
    // ----------------------------------------
    // Reply sink
    // ----------------------------------------
    // Random stalls keep the two-entry reply buffer filling up
    always @(posedge sys_clk_i) begin
        if (tx_valid_i && tx_ready_o) got.push_back(tx_token_i);
        tx_ready_o <= ($urandom % 4) != 0;
    end
    // ----------------------------------------
    // Register bank, registers 0 to F in each bank
    // ----------------------------------------
    assign done_now = !rst_i && !reg_req_i && busy_reg && wait_reg == 2'h0;
    always @(posedge sys_clk_i) begin
        reg_ack_o <= done_now;
        // Read data only holds meaning with ack
        reg_rdata_o <= (done_now && !we_reg) ? mem_reg[{req_reg.node_bank, req_reg.regnum[3:0]}] : ~reg_rdata_o;
        if (rst_i) begin
            busy_reg <= 1'b0;
        end else if (reg_req_i) begin
            busy_reg <= 1'b1;
            req_reg <= reg_i;
            we_reg <= reg_we_i;
            wait_reg <= 2'($urandom % 4);
        end else if (busy_reg && wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end else if (busy_reg) begin
            busy_reg <= 1'b0;
            reg_err_o <= req_reg.regnum > 16'h000F;
            if (req_reg.regnum <= 16'h000F && we_reg) mem_reg[{req_reg.node_bank, req_reg.regnum[3:0]}] <= req_reg.wdata;
        end
    end
endmodule // cfg_far_end_model
`default_nettype wire

//--- dv/test_cfg_msg_responder.sv
// Self-checking testbench of the configuration message responder
`timescale 1ns/1ps
`default_nettype none
module test_cfg_msg_responder;
    import cfg_msg_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] dest_i = 32'h0;
    logic rx_valid_i = 1'b0;
    token_t rx_token_i = '0;
    logic rx_ready_o, tx_valid_o, tx_ready_i, reg_req_o, reg_we_o, reg_ack_i, reg_err_i;
    token_t tx_token_o;
    logic [23:0] reply_addr_o;
    reg_req_t reg_o;
    logic [31:0] reg_rdata_i;
    logic [31:0] shadow [0:31] = '{default: 32'h0};
    int err_total = 0;
    int comparisons = 0;
    cfg_msg_responder cfg_msg_responder_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .dest_i(dest_i),
        .rx_valid_i(rx_valid_i), .rx_token_i(rx_token_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
        .tx_token_o(tx_token_o), .tx_ready_i(tx_ready_i), .reply_addr_o(reply_addr_o), .reg_req_o(reg_req_o),
        .reg_we_o(reg_we_o), .reg_o(reg_o), .reg_ack_i(reg_ack_i), .reg_err_i(reg_err_i), .reg_rdata_i(reg_rdata_i));
    cfg_far_end_model cfg_far_end_model_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o),
        .tx_token_i(tx_token_o), .tx_ready_o(tx_ready_i), .reg_req_i(reg_req_o), .reg_we_i(reg_we_o),
        .reg_i(reg_o), .reg_ack_o(reg_ack_i), .reg_err_o(reg_err_i), .reg_rdata_o(reg_rdata_i));
    always #10 sys_clk_i = ~sys_clk_i;
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] ps_res_id(input logic [15:0] rn);
        return (32'(rn) << PS_SHIFT) | {24'h000000, PS_RES_TYPE};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Request driver: called just after a rising edge
    // ----------------------------------------
    task automatic put(input logic c, input logic [7:0] d);
        rx_valid_i <= 1'b1;
        rx_token_i <= '{ctrl: c, data: d};
        do @(negedge sys_clk_i); while (rx_ready_o !== 1'b1);
        @(posedge sys_clk_i);
    endtask
    // Bad: 0 well formed, 1 unknown command, 2 end token in place of data, 3 extra byte before end
    task automatic run_msg(input logic [7:0] cmd, input logic [31:0] dest, input logic [23:0] raddr,
                           input logic [15:0] rn, input logic [31:0] wd, input int bad);
        token_t exp_q[$];
        logic ok;
        logic bank_ok;
        logic [4:0] idx;
        dest_i <= dest;
        put(1'b1, cmd);
        for (int i = 2; i >= 0; i--) put(1'b0, raddr[8*i+:8]);
        for (int i = 1; i >= 0; i--) put(1'b0, rn[8*i+:8]);
        if (cmd == TOK_WRITE && bad == 0) for (int i = 3; i >= 0; i--) put(1'b0, wd[8*i+:8]);
        if (bad == 3) put(1'b0, 8'h5A);
        put(1'b1, TOK_END);
        rx_valid_i <= 1'b0;
        bank_ok = dest[15:0] == TILE_BANK_LOW || dest[15:0] == NODE_BANK_LOW;
        ok = bad == 0 && bank_ok && rn < 16'h0010;
        idx = {dest[15:0] == NODE_BANK_LOW, rn[3:0]};
        if (ok && cmd == TOK_WRITE) shadow[idx] = wd;
        if (!(cmd == TOK_WRITE && bad == 0 && bank_ok && raddr[7:0] == NO_REPLY_LOW)) begin
            exp_q.push_back('{ctrl: 1'b1, data: ok ? TOK_ACK : TOK_NACK});
            if (ok && cmd == TOK_READ) for (int i = 3; i >= 0; i--) exp_q.push_back('{ctrl: 1'b0, data: shadow[idx][8*i+:8]});
            exp_q.push_back('{ctrl: 1'b1, data: TOK_END});
        end
        for (int w = 0; w < 400 && cfg_far_end_model_i.got.size() < exp_q.size(); w++) @(posedge sys_clk_i);
        repeat (12) @(posedge sys_clk_i);
        check("reply length", cfg_far_end_model_i.got.size(), exp_q.size());
        if (exp_q.size() > 0) check("reply address", reply_addr_o, raddr);
        foreach (exp_q[k]) if (k < cfg_far_end_model_i.got.size())
            check("reply token", 32'(cfg_far_end_model_i.got[k]), 32'(exp_q[k]));
        cfg_far_end_model_i.got.delete();
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #1000000;
        err_total++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        void'($urandom(32'h63D0));
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        check("status resource id", ps_res_id(16'h0003), 32'h0000030B);
        // Same register number in both banks must stay apart
        for (int b = 0; b < 2; b++) begin
            run_msg(TOK_WRITE, {16'h0042, b ? NODE_BANK_LOW : TILE_BANK_LOW}, 24'h012345, 16'h0003, $urandom, 0);
            run_msg(TOK_READ, 32'h0042C20C, 24'h012346, 16'h0003, 32'h0, 0);
            run_msg(TOK_READ, 32'h0042C30C, 24'h012347, 16'h0003, 32'h0, 0);
        end
        $display("test banks done");
        // Suppressed write still lands in the bank
        run_msg(TOK_WRITE, 32'h0001C30C, 24'h0100FF, 16'h000F, 32'hA5C3_0F1E, 0);
        run_msg(TOK_READ, 32'h0001C30C, 24'h0100FF, 16'h000F, 32'h0, 0);
        $display("test suppress done");
        run_msg(TOK_WRITE, 32'h0001C20C, 24'h010203, 16'h0020, 32'h1, 0);
        run_msg(TOK_READ, 32'h0001C20C, 24'h010203, 16'hFFFF, 32'h0, 0);
        run_msg(TOK_WRITE, 32'h0001C40C, 24'h010204, 16'h0001, 32'h2, 0);
        run_msg(8'hC5, 32'h0001C20C, 24'h010205, 16'h0001, 32'h0, 1);
        run_msg(TOK_WRITE, 32'h0001C30C, 24'h0102FF, 16'h0001, 32'h3, 2);
        run_msg(TOK_READ, 32'h0001C20C, 24'h010206, 16'h0001, 32'h0, 3);
        $display("test failures done");
        for (int n = 0; n < 40; n++) begin
            r = $urandom;
            run_msg(r[0] ? TOK_WRITE : TOK_READ, {r[31:16], r[3:1] == 3'h0 ? 16'hC21C : (r[4] ? NODE_BANK_LOW : TILE_BANK_LOW)},
                    {r[23:8], r[5] ? 8'hFF : r[15:8]}, {11'h0, r[10:6]}, $urandom, 0);
        end
        $display("test random done");
        close_out();
    end
endmodule // test_cfg_msg_responder
`default_nettype wire

//--- include/cfg_msg_pkg.sv
// Package for the configuration message responder
package cfg_msg_pkg;
    // ----------------------------------------
    // Token values
    // ----------------------------------------
    localparam logic [7:0] TOK_WRITE = 8'hC0;
    localparam logic [7:0] TOK_READ = 8'hC1;
    localparam logic [7:0] TOK_END = 8'h01;
    localparam logic [7:0] TOK_ACK = 8'h03;
    localparam logic [7:0] TOK_NACK = 8'h04;
    localparam logic [7:0] NO_REPLY_LOW = 8'hFF;
    // ----------------------------------------
    // Bank destinations (low 16 bits)
    // ----------------------------------------
    localparam logic [15:0] TILE_BANK_LOW = 16'hC20C;
    localparam logic [15:0] NODE_BANK_LOW = 16'hC30C;
    // ----------------------------------------
    // Field byte counts
    // ----------------------------------------
    localparam logic [2:0] RADDR_BYTES = 3'h3;
    localparam logic [2:0] REGNUM_BYTES = 3'h2;
    localparam logic [2:0] DATA_BYTES = 3'h4;
    localparam int PS_SHIFT = 8;
    localparam logic [7:0] PS_RES_TYPE = 8'h0B;

    // One token of the channel: control flag plus byte
    typedef struct packed {
        logic ctrl;
        logic [7:0] data;
    } token_t;

    // Register access toward the bank
    typedef struct packed {
        logic node_bank;
        logic [15:0] regnum;
        logic [31:0] wdata;
    } reg_req_t;
endpackage

//--- rtl/cfg_msg_responder.sv
// Configuration register access responder over the channel token stream
`timescale 1ns/1ps
`default_nettype none

module cfg_msg_responder
    import cfg_msg_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Destination this stream was addressed to
    input wire logic [31:0] dest_i,
    // Incoming request tokens
    input wire logic rx_valid_i,
    input wire token_t rx_token_i,
    output logic rx_ready_o,
    // Outgoing reply tokens
    output logic tx_valid_o,
    output token_t tx_token_o,
    input wire logic tx_ready_i,
    // Reply destination for the current answer
    output logic [23:0] reply_addr_o,
    // Register bank access
    output logic reg_req_o,
    output logic reg_we_o,
    output reg_req_t reg_o,
    input wire logic reg_ack_i,
    input wire logic reg_err_i,
    input wire logic [31:0] reg_rdata_i
);
    typedef enum {S_CMD, S_RADDR, S_REGNUM, S_DATA, S_END, S_DRAIN, S_ACCESS, S_REPLY} state_t;

    state_t state_reg;
    logic is_write_reg;
    logic bad_reg;
    logic [2:0] cnt_reg;
    logic [23:0] raddr_reg;
    logic [15:0] regnum_reg;
    logic [31:0] data_reg;
    logic ok_reg;
    logic [2:0] rep_idx_reg;
    logic bank_tile;
    logic bank_node;
    logic rx_fire;
    logic end_fire;
    logic push_valid;
    token_t push_token;
    logic push_ready;
    logic [2:0] rep_last;

    assign rx_fire = rx_valid_i && rx_ready_o;
    assign end_fire = rx_fire && rx_token_i.ctrl && (rx_token_i.data == TOK_END);
    assign bank_tile = (dest_i[15:0] == TILE_BANK_LOW);
    assign bank_node = (dest_i[15:0] == NODE_BANK_LOW);

    // ----------------------------------------
    // Request parsing
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= S_CMD;
            is_write_reg <= 1'b0;
            bad_reg <= 1'b0;
            cnt_reg <= 3'h0;
            raddr_reg <= 24'h000000;
            regnum_reg <= 16'h0000;
            data_reg <= 32'h00000000;
            ok_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_CMD: begin
                    if (rx_fire) begin
                        is_write_reg <= (rx_token_i.data == TOK_WRITE);
                        // Unknown command still parses its fields, so its reply address is known
                        bad_reg <= !(rx_token_i.ctrl && (rx_token_i.data == TOK_WRITE ||
                                     rx_token_i.data == TOK_READ)) || !(bank_tile || bank_node);
                        cnt_reg <= 3'h0;
                        if (!rx_token_i.ctrl || rx_token_i.data == TOK_END) begin
                            state_reg <= rx_token_i.ctrl ? S_REPLY : S_DRAIN;
                        end else begin
                            state_reg <= S_RADDR;
                        end
                    end
                end
                S_RADDR, S_REGNUM, S_DATA: begin
                    if (rx_fire) begin
                        if (rx_token_i.ctrl) begin
                            bad_reg <= 1'b1;
                            state_reg <= (rx_token_i.data == TOK_END) ? S_REPLY : S_DRAIN;
                        end else begin
                            cnt_reg <= cnt_reg + 3'h1;
                            if (state_reg == S_RADDR) begin
                                raddr_reg <= {raddr_reg[15:0], rx_token_i.data};
                                if (cnt_reg == RADDR_BYTES - 3'h1) begin
                                    state_reg <= S_REGNUM;
                                    cnt_reg <= 3'h0;
                                end
                            end else if (state_reg == S_REGNUM) begin
                                regnum_reg <= {regnum_reg[7:0], rx_token_i.data};
                                if (cnt_reg == REGNUM_BYTES - 3'h1) begin
                                    state_reg <= is_write_reg ? S_DATA : S_END;
                                    cnt_reg <= 3'h0;
                                end
                            end else begin
                                data_reg <= {data_reg[23:0], rx_token_i.data};
                                if (cnt_reg == DATA_BYTES - 3'h1) begin
                                    state_reg <= S_END;
                                end
                            end
                        end
                    end
                end
                S_END: begin
                    if (rx_fire) begin
                        if (rx_token_i.ctrl && rx_token_i.data == TOK_END) begin
                            state_reg <= bad_reg ? S_REPLY : S_ACCESS;
                        end else begin
                            bad_reg <= 1'b1;
                            state_reg <= S_DRAIN;
                        end
                    end
                end
                S_DRAIN: begin
                    // Resynchronise on the next end token
                    if (rx_fire && rx_token_i.ctrl && rx_token_i.data == TOK_END) begin
                        bad_reg <= 1'b1;
                        state_reg <= S_REPLY;
                    end
                end
                S_ACCESS: begin
                    if (reg_ack_i) begin
                        ok_reg <= !reg_err_i;
                        if (!is_write_reg) begin
                            data_reg <= reg_rdata_i;
                        end
                        state_reg <= S_REPLY;
                    end
                end
                S_REPLY: begin
                    if (push_ready && (rep_idx_reg == rep_last)) begin
                        state_reg <= S_CMD;
                        ok_reg <= 1'b0;
                        bad_reg <= 1'b0;
                    end
                end
                default: state_reg <= S_CMD;
            endcase
        end
    end

    // ----------------------------------------
    // Register bank access
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_req_o <= 1'b0;
            reg_we_o <= 1'b0;
            reg_o <= '0;
            reply_addr_o <= 24'h000000;
        end else begin
            // One pulse per access: a repeated pulse would start a second access
            reg_req_o <= (state_reg == S_END) && end_fire && !bad_reg;
            if (state_reg == S_END && rx_fire) begin
                reg_we_o <= is_write_reg;
                reg_o.node_bank <= bank_node;
                reg_o.regnum <= regnum_reg;
                reg_o.wdata <= data_reg;
            end
            // Failure replies need the sender's address too
            if (end_fire) begin
                reply_addr_o <= raddr_reg;
            end
        end
    end

    // ----------------------------------------
    // Reply sequencing
    // ----------------------------------------
    // Success read: ack, 4 data bytes, end; otherwise two tokens
    assign rep_last = (ok_reg && !bad_reg && !is_write_reg) ? 3'h5 : 3'h1;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rep_idx_reg <= 3'h0;
        end else if (state_reg != S_REPLY) begin
            rep_idx_reg <= 3'h0;
        end else if (push_ready) begin
            rep_idx_reg <= rep_idx_reg + 3'h1;
        end
    end

    always_comb begin
        push_valid = (state_reg == S_REPLY);
        push_token = '{ctrl: 1'b1, data: TOK_END};
        if (rep_idx_reg == 3'h0) begin
            push_token.data = (ok_reg && !bad_reg) ? TOK_ACK : TOK_NACK;
        end else if (rep_idx_reg != rep_last) begin
            push_token.ctrl = 1'b0;
            case (rep_idx_reg)
                3'h1: push_token.data = data_reg[31:24];
                3'h2: push_token.data = data_reg[23:16];
                3'h3: push_token.data = data_reg[15:8];
                default: push_token.data = data_reg[7:0];
            endcase
        end
        // Suppressed write reply is dropped, sequencing still steps
        if (is_write_reg && !bad_reg && raddr_reg[7:0] == NO_REPLY_LOW) begin
            push_valid = 1'b0;
        end
    end

    // ----------------------------------------
    // Two-entry output buffer
    // ----------------------------------------
    // Stall by the receiver holds the sequencer, no token is lost
    token_t buf_mem [2];
    logic buf_wp_reg;
    logic buf_rp_reg;
    logic [1:0] buf_cnt_reg;
    logic suppress;
    assign suppress = (state_reg == S_REPLY) && !push_valid;
    assign push_ready = suppress || (buf_cnt_reg != 2'h2);

    // Every end token leads to access or reply; the last reply token reopens
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_ready_o <= 1'b1;
        end else if (end_fire) begin
            rx_ready_o <= 1'b0;
        end else if (state_reg == S_REPLY && push_ready && (rep_idx_reg == rep_last)) begin
            rx_ready_o <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            buf_wp_reg <= 1'b0;
            buf_rp_reg <= 1'b0;
            buf_cnt_reg <= 2'h0;
            tx_valid_o <= 1'b0;
            tx_token_o <= '0;
        end else begin
            logic do_push;
            logic do_pop;
            do_push = push_valid && (buf_cnt_reg != 2'h2);
            do_pop = (buf_cnt_reg != 2'h0) && (!tx_valid_o || tx_ready_i);
            if (do_push) begin
                buf_mem[buf_wp_reg] <= push_token;
                buf_wp_reg <= !buf_wp_reg;
            end
            if (do_pop) begin
                tx_token_o <= buf_mem[buf_rp_reg];
                buf_rp_reg <= !buf_rp_reg;
                tx_valid_o <= 1'b1;
            end else if (tx_ready_i) begin
                tx_valid_o <= 1'b0;
            end
            buf_cnt_reg <= buf_cnt_reg + {1'b0, do_push} - {1'b0, do_pop};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_NO_REPLY_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg == S_REPLY && is_write_reg && !bad_reg && raddr_reg[7:0] == NO_REPLY_LOW) |-> !push_valid)
        else $error("suppressed write reply pushed");
    AST_FAIL_ON_BAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (push_valid && rep_idx_reg == 3'h0 && bad_reg) |-> push_token.data == TOK_NACK)
        else $error("bad request not failed");
    AST_REPLY_ENDS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (push_valid && rep_idx_reg == rep_last) |-> push_token.ctrl && push_token.data == TOK_END)
        else $error("reply not closed by end token");
    AST_READ_MSB: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (push_valid && rep_idx_reg == 3'h1 && rep_last == 3'h5) |-> push_token.data == data_reg[31:24])
        else $error("read data not msb first");
    AST_RADDR_SHIFT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg == S_RADDR && rx_fire && !rx_token_i.ctrl) |=> raddr_reg[7:0] == $past(rx_token_i.data))
        else $error("reply address byte order");
    AST_WRITE_HAS_DATA: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg == S_REGNUM && rx_fire && !rx_token_i.ctrl && cnt_reg == 3'h1 && is_write_reg)
        |=> state_reg == S_DATA)
        else $error("write skipped data");
    AST_READ_NO_DATA: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg == S_REGNUM && rx_fire && !rx_token_i.ctrl && cnt_reg == 3'h1 && !is_write_reg)
        |=> state_reg == S_END)
        else $error("read expected data");
    AST_BANK_SELECT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg == S_CMD && rx_fire && !bank_tile && !bank_node) |=> bad_reg)
        else $error("unknown bank accepted");
endmodule // cfg_msg_responder

`default_nettype wire
